/* File: adc_result_and_delay_regs.sv */
// result, comparator snapshot and pair delay registers with their link side access
//
// What this block does
// - eight 24-bit result registers hold each channel's newest result, host cannot write
// - a read transaction freezes the result words being shifted out
// - conversions arriving during a read still update the holding registers
// - with ready link on, all results update together on the lagging ready
// - results read singly or as a linked sequence per read increment select
// - corrected codes replace raw codes when offset or gain correction is on
// - result words presented as 16, 24 or 32 bits per width select
// - result code sits in bits 23..0, signed, msb at 23, resets to zero
// - comparator snapshot refreshed once per modulator clock period
// - four snapshot bits per channel, channel 7 on top, channel 0 lowest
// - snapshot is 32 bits and resets to the zero-volt input pattern
// - writing either delay register restarts every active converter
// - upper delay register holds pair 6/7 in 23..12 and 4/5 in 11..0
// - lower delay register holds pair 2/3 in 23..12 and 0/1 in 11..0
// - delay fields are unsigned modulator clock counts, reset to zero
// - ready link gives one ready pulse from the lagging converter, else per converter
// - read address steps over map, types, groups, or stays, per select
`timescale 1ns/1ps
`default_nettype none

module adc_result_and_delay_regs
    import adc_result_pkg::*;
(
    // core clock and control
    input  wire logic                         clk,
    input  wire logic                         sys_rst,
    input  wire logic                         ce,
    // modulator and converter side
    input  wire logic                         mod_tick,
    input  wire logic [WORD_W-1:0]            comp_in,
    input  wire logic [NUM_CH-1:0]            conv_ready,
    input  wire logic [NUM_CH-1:0][RES_W-1:0] conv_raw,
    input  wire logic [NUM_CH-1:0][RES_W-1:0] conv_corr,
    input  wire logic [NUM_CH-1:0]            chan_active,
    output logic      [NUM_CH-1:0]            chan_restart,
    output logic      [NUM_CH-1:0]            chan_start,
    output logic                              ready_pin_n,
    // configuration bits held elsewhere
    input  wire logic                         ready_link_enable,
    input  wire logic                         offset_correction_enable,
    input  wire logic                         gain_correction_enable,
    input  wire logic [1:0]                   result_width_select,
    input  wire logic [1:0]                   read_increment_select,
    // serial link side
    input  wire logic                         link_clk,
    input  wire logic                         link_cs_n,
    input  wire logic                         link_rd_start,
    input  wire logic [ADDR_W-1:0]            link_rd_addr,
    input  wire logic                         link_rd_next,
    output logic                              link_rd_ready,
    output logic      [WORD_W-1:0]            link_rdata,
    input  wire logic                         link_wr,
    input  wire logic [ADDR_W-1:0]            link_wr_addr,
    input  wire logic [WORD_W-1:0]            link_wr_data,
    output logic                              link_wr_ready
);

    core_state_t cq;
    core_state_t cn;
    link_state_t lq;
    link_state_t ln;

    // shapes a result code into the selected word width
    function automatic logic [WORD_W-1:0] fmt_word(input logic [RES_W-1:0] v,
                                                   input logic [1:0]       sel);
        logic [16:0] rnd;
        logic [15:0] w16;
        rnd = {v[RES_W-1], v[RES_W-1:SAT16_LSB]} + {16'h0000, v[SAT16_LSB-1]};
        // rounding can only overflow upward; clip instead of wrapping to negative
        if (!v[RES_W-1] && rnd[15]) begin
            w16 = 16'h7fff;
        end else begin
            w16 = rnd[15:0];
        end
        case (sel)
            WSEL_16:      fmt_word = {16'h0000, w16};
            WSEL_24:      fmt_word = {8'h00, v};
            WSEL_32_ZERO: fmt_word = {v, 8'h00};
            default:      fmt_word = {{8{v[RES_W-1]}}, v};
        endcase
    endfunction

    // next read address for the chosen looping behaviour
    function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a,
                                                    input logic [1:0]        sel);
        logic [ADDR_W-1:0] inc;
        inc = a + 5'h01;
        next_addr = a;
        case (sel)
            INC_ALL: begin
                next_addr = (a == ADDR_LAST) ? ADDR_RESULT_0 : inc;
            end
            INC_TYPE: begin
                if (a == ADDR_RESULT_7) begin
                    next_addr = ADDR_RESULT_0;
                end else if (a == ADDR_CFG_END) begin
                    next_addr = ADDR_COMP;
                end else if (a == ADDR_CAL_END) begin
                    next_addr = ADDR_CAL_0;
                end else if (a != ADDR_LAST) begin
                    next_addr = inc;
                end
            end
            INC_GROUP: begin
                if (a <= ADDR_RESULT_7) begin
                    next_addr = a[0] ? (a - 5'h01) : inc;
                end else if (a <= ADDR_CFG_GRP) begin
                    next_addr = (a == ADDR_CFG_GRP) ? ADDR_COMP : inc;
                end else if (a <= ADDR_CFG_END) begin
                    next_addr = (a == ADDR_CFG_END) ? (ADDR_CFG_GRP + 5'h01) : inc;
                end else if (a <= ADDR_CAL_END) begin
                    next_addr = a[0] ? inc : (a - 5'h01);
                end
            end
            default: begin
                next_addr = a;
            end
        endcase
    endfunction

    // ---------------- modulator clock side ----------------
    always_comb begin
        logic [NUM_CH-1:0][RES_W-1:0] chosen;
        logic [NUM_CH-1:0]            got;
        logic [2*RES_W-1:0]           dly_all;
        logic [DLY_W-1:0]             fld;
        logic                         wr_evt;
        logic                         do_restart;
        chosen     = conv_raw;
        got        = conv_ready & chan_active;
        dly_all    = '0;
        fld        = '0;
        wr_evt     = 1'b0;
        do_restart = 1'b0;
        cn         = cq;
        cn.ready_n = 1'b1;
        cn.restart = '0;
        cn.start   = '0;

        // crossings from the link side: level and write toggle
        cn.cs_s1   = lq.active;
        cn.cs_s2   = cq.cs_s1;
        cn.cs_s3   = cq.cs_s2;
        cn.wr_s1   = lq.wr_tgl;
        cn.wr_s2   = cq.wr_s1;
        cn.wr_s3   = cq.wr_s2;
        cn.ack_tgl = cq.wr_s2;
        wr_evt     = cq.wr_s2 ^ cq.wr_s3;

        if (offset_correction_enable || gain_correction_enable) begin
            chosen = conv_corr;
        end

        for (int c = 0; c < NUM_CH; c++) begin
            if (conv_ready[c]) begin
                // holding registers keep taking data even mid-read
                cn.pend[c] = chosen[c];
                if (!ready_link_enable) begin
                    cn.result[c] = chosen[c];
                end
            end
        end

        if (ready_link_enable) begin
            cn.seen = cq.seen | got;
            // all active channels reported: this is the most lagging one
            if ((chan_active != '0) && ((cn.seen & chan_active) == chan_active)) begin
                cn.result  = cn.pend;
                cn.seen    = '0;
                cn.ready_n = 1'b0;
            end
        end else begin
            cn.seen    = '0;
            cn.ready_n = ~(|got);
        end

        if (mod_tick) begin
            cn.comp = comp_in;
        end

        if (wr_evt) begin
            // lq write fields are held still until the acknowledge returns
            if (lq.wr_addr == ADDR_COMP) begin
                cn.comp = lq.wr_data;
            end else if (lq.wr_addr == ADDR_DLY_HI) begin
                cn.dly_hi  = lq.wr_data[RES_W-1:0];
                do_restart = 1'b1;
            end else if (lq.wr_addr == ADDR_DLY_LO) begin
                cn.dly_lo  = lq.wr_data[RES_W-1:0];
                do_restart = 1'b1;
            end
            // result addresses and the rest of the map fall through untouched
        end

        dly_all = {cn.dly_hi, cn.dly_lo};
        for (int p = 0; p < NUM_PAIRS; p++) begin
            fld = dly_all[p*DLY_W +: DLY_W];
            if (do_restart) begin
                cn.dly_cnt[p]    = fld;
                cn.start[2*p+1]  = chan_active[2*p+1];
                cn.dly_run[p]    = (fld != '0);
                cn.start[2*p]    = chan_active[2*p] && (fld == '0);
            end else if (cq.dly_run[p] && mod_tick) begin
                // paired channel lags its reference by the field in modulator periods
                cn.dly_cnt[p] = cq.dly_cnt[p] - 12'h001;
                if (cq.dly_cnt[p] == 12'h001) begin
                    cn.dly_run[p]  = 1'b0;
                    cn.start[2*p]  = chan_active[2*p];
                end
            end
        end
        if (do_restart) begin
            cn.restart = chan_active;
            cn.seen    = '0;
        end

        // take the transfer copy once per transaction, it then stays put
        if (cq.cs_s2 && !cq.cs_s3) begin
            for (int c = 0; c < NUM_CH; c++) begin
                cn.snap[c] = fmt_word(cq.result[c], result_width_select);
            end
            cn.snap[ADDR_COMP]   = cq.comp;
            cn.snap[ADDR_DLY_HI] = {8'h00, cq.dly_hi};
            cn.snap[ADDR_DLY_LO] = {8'h00, cq.dly_lo};
            cn.snap_inc          = read_increment_select;
            cn.snap_tgl          = ~cq.snap_tgl;
        end

        if (sys_rst) begin
            cn         = '0;
            cn.result  = {NUM_CH{RESULT_RST}};
            cn.pend    = {NUM_CH{RESULT_RST}};
            cn.comp    = COMP_RST;
            cn.dly_hi  = DLY_RST;
            cn.dly_lo  = DLY_RST;
            cn.ready_n = 1'b1;
        end else if (!ce) begin
            cn = cq;
        end
    end

    always_ff @(posedge clk) begin
        cq <= cn;
    end

    assign ready_pin_n  = cq.ready_n;
    assign chan_restart = cq.restart;
    assign chan_start   = cq.start;

    // ---------------- link clock side ----------------
    always_comb begin
        logic busy;
        busy       = lq.wr_tgl ^ lq.ack_s2;
        ln         = lq;
        ln.rst_s1  = sys_rst;
        ln.rst_s2  = lq.rst_s1;
        ln.active  = ~link_cs_n;
        ln.snap_s1 = cq.snap_tgl;
        ln.snap_s2 = lq.snap_s1;
        ln.snap_s3 = lq.snap_s2;
        ln.ack_s1  = cq.ack_tgl;
        ln.ack_s2  = lq.ack_s1;

        if (lq.snap_s2 ^ lq.snap_s3) begin
            ln.snap_ok = 1'b1;
        end
        if (link_cs_n) begin
            ln.snap_ok = 1'b0;
        end

        if (link_wr && !busy) begin
            ln.wr_addr = link_wr_addr;
            ln.wr_data = link_wr_data;
            ln.wr_tgl  = ~lq.wr_tgl;
        end

        if (link_rd_start) begin
            ln.addr = link_rd_addr;
        end else if (link_rd_next && lq.snap_ok) begin
            if (lq.addr <= ADDR_DLY_LO) begin
                ln.rdata = cq.snap[lq.addr];
            end else begin
                ln.rdata = '0;
            end
            ln.addr = next_addr(lq.addr, cq.snap_inc);
        end

        if (lq.rst_s2) begin
            ln        = '0;
            ln.rst_s1 = sys_rst;
            ln.rst_s2 = lq.rst_s1;
        end
    end

    always_ff @(posedge link_clk) begin
        lq <= ln;
    end

    assign link_rd_ready = lq.snap_ok;
    assign link_rdata    = lq.rdata;
    assign link_wr_ready = ~(lq.wr_tgl ^ lq.ack_s2);

endmodule

`default_nettype wire

/* File: adc_result_asserts.sv */
// concurrent checks on the ports of the result and delay register block
`timescale 1ns/1ps
`default_nettype none
module adc_result_asserts
    import adc_result_pkg::*;
(
    // core side
    input wire logic              clk,
    input wire logic              sys_rst,
    input wire logic [NUM_CH-1:0] conv_ready,
    input wire logic [NUM_CH-1:0] chan_active,
    input wire logic [NUM_CH-1:0] chan_restart,
    input wire logic [NUM_CH-1:0] chan_start,
    input wire logic              ready_pin_n,
    input wire logic              ready_link_enable,
    // link side
    input wire logic              link_clk,
    input wire logic              link_cs_n,
    input wire logic              link_rd_next,
    input wire logic              link_rd_ready,
    input wire logic [WORD_W-1:0] link_rdata,
    input wire logic              link_wr,
    input wire logic              link_wr_ready
);
    property p_own_ready;
        @(posedge clk) disable iff (sys_rst)
        !ready_link_enable && |(conv_ready & chan_active) |=> !ready_pin_n;
    endproperty
    a_own_ready: assert property (p_own_ready) else $error("ready pulse missing");
    property p_ready_cause;
        @(posedge clk) disable iff (sys_rst) !ready_pin_n |-> $past(|(conv_ready & chan_active));
    endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("ready without cause");
    property p_ready_one;
        @(posedge clk) disable iff (sys_rst) $fell(ready_pin_n) |=> ready_pin_n;
    endproperty
    a_ready_one: assert property (p_ready_one) else $error("ready pulse too long");
    property p_restart_mask;
        @(posedge clk) disable iff (sys_rst) |chan_restart |-> chan_restart == chan_active;
    endproperty
    a_restart_mask: assert property (p_restart_mask) else $error("restart mask wrong");
    property p_restart_one;
        @(posedge clk) disable iff (sys_rst)
        |chan_restart |=> chan_restart == 8'h00 && !link_wr_ready;
    endproperty
    a_restart_one: assert property (p_restart_one) else $error("restart not a pulse");
    property p_ref_start;
        @(posedge clk) disable iff (sys_rst)
        |chan_restart |-> (chan_start & 8'haa) == (chan_restart & 8'haa);
    endproperty
    a_ref_start: assert property (p_ref_start) else $error("reference start late");
    property p_freeze;
        @(posedge link_clk) disable iff (sys_rst)
        !link_cs_n && !$past(link_cs_n) && !$past(link_rd_next) |-> $stable(link_rdata);
    endproperty
    a_freeze: assert property (p_freeze) else $error("read word changed");
    property p_wr_busy;
        @(posedge link_clk) disable iff (sys_rst) link_wr && link_wr_ready |=> !link_wr_ready;
    endproperty
    a_wr_busy: assert property (p_wr_busy) else $error("write not taken");
    property p_rdy_idle;
        @(posedge link_clk) disable iff (sys_rst) link_cs_n [*3] |-> !link_rd_ready;
    endproperty
    a_rdy_idle: assert property (p_rdy_idle) else $error("ready outside frame");
endmodule
bind adc_result_and_delay_regs adc_result_asserts chk_i (.clk, .sys_rst, .conv_ready,
    .chan_active, .chan_restart, .chan_start, .ready_pin_n, .ready_link_enable, .link_clk,
    .link_cs_n, .link_rd_next, .link_rd_ready, .link_rdata, .link_wr, .link_wr_ready);
`default_nettype wire

/* File: adc_result_pkg.sv */
// constants, codes and state records shared by the result and delay register block
package adc_result_pkg;

    localparam int NUM_CH     = 8;
    localparam int NUM_PAIRS  = 4;
    localparam int RES_W      = 24;
    localparam int WORD_W     = 32;
    localparam int ADDR_W     = 5;
    localparam int DLY_W      = 12;
    localparam int SNAP_WORDS = 11;

    // register offsets
    localparam logic [4:0] ADDR_RESULT_0 = 5'h00;
    localparam logic [4:0] ADDR_RESULT_7 = 5'h07;
    localparam logic [4:0] ADDR_COMP     = 5'h08;
    localparam logic [4:0] ADDR_DLY_HI   = 5'h09;
    localparam logic [4:0] ADDR_DLY_LO   = 5'h0a;
    localparam logic [4:0] ADDR_CFG_GRP  = 5'h0b;
    localparam logic [4:0] ADDR_CFG_END  = 5'h0e;
    localparam logic [4:0] ADDR_CAL_0    = 5'h0f;
    localparam logic [4:0] ADDR_CAL_END  = 5'h1e;
    localparam logic [4:0] ADDR_LAST     = 5'h1f;

    // field positions
    localparam int DLY_UPPER_LSB = 12;
    localparam int SAT16_LSB     = 8;

    // values after reset
    localparam logic [31:0] COMP_RST   = 32'h33333333;
    localparam logic [23:0] RESULT_RST = 24'h000000;
    localparam logic [23:0] DLY_RST    = 24'h000000;

    // result_width_select codes
    localparam logic [1:0] WSEL_16      = 2'b00;
    localparam logic [1:0] WSEL_24      = 2'b01;
    localparam logic [1:0] WSEL_32_ZERO = 2'b10;
    localparam logic [1:0] WSEL_32_SIGN = 2'b11;

    // read_increment_select codes
    localparam logic [1:0] INC_STATIC = 2'b00;
    localparam logic [1:0] INC_GROUP  = 2'b01;
    localparam logic [1:0] INC_TYPE   = 2'b10;
    localparam logic [1:0] INC_ALL    = 2'b11;

    // state of the modulator clock side
    typedef struct packed {
        logic [NUM_CH-1:0][RES_W-1:0]       result;
        logic [NUM_CH-1:0][RES_W-1:0]       pend;
        logic [NUM_CH-1:0]                  seen;
        logic [WORD_W-1:0]                  comp;
        logic [RES_W-1:0]                   dly_hi;
        logic [RES_W-1:0]                   dly_lo;
        logic [NUM_PAIRS-1:0][DLY_W-1:0]    dly_cnt;
        logic [NUM_PAIRS-1:0]               dly_run;
        logic [NUM_CH-1:0]                  restart;
        logic [NUM_CH-1:0]                  start;
        logic                               ready_n;
        logic                               cs_s1;
        logic                               cs_s2;
        logic                               cs_s3;
        logic                               wr_s1;
        logic                               wr_s2;
        logic                               wr_s3;
        logic                               ack_tgl;
        logic                               snap_tgl;
        logic [1:0]                         snap_inc;
        logic [SNAP_WORDS-1:0][WORD_W-1:0]  snap;
    } core_state_t;

    // state of the link clock side
    typedef struct packed {
        logic              rst_s1;
        logic              rst_s2;
        logic              active;
        logic              snap_s1;
        logic              snap_s2;
        logic              snap_s3;
        logic              snap_ok;
        logic              ack_s1;
        logic              ack_s2;
        logic              wr_tgl;
        logic [ADDR_W-1:0] wr_addr;
        logic [WORD_W-1:0] wr_data;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] rdata;
    } link_state_t;

endpackage

/* File: host_link_model.sv */
// host model driving the link pins of the register block
`timescale 1ns/1ps
`default_nettype none
module host_link_model
    import adc_result_pkg::*;
(
    // link pins driven by the host
    output logic              link_clk,
    output logic              link_cs_n,
    output logic              link_rd_start,
    output logic [ADDR_W-1:0] link_rd_addr,
    output logic              link_rd_next,
    output logic              link_wr,
    output logic [ADDR_W-1:0] link_wr_addr,
    output logic [WORD_W-1:0] link_wr_data,
    // answers from the device
    input  wire logic              link_rd_ready,
    input  wire logic [WORD_W-1:0] link_rdata,
    input  wire logic              link_wr_ready
);
    logic run;
    // clock idles low between frames, but runs through reset so the link side clears
    initial begin
        {run, link_clk, link_cs_n, link_rd_start, link_rd_next, link_wr} = 6'h28;
        {link_rd_addr, link_wr_addr, link_wr_data} = 42'h155a5a5a5a5;
        #1.3;
        forever #7.5 if (run || link_clk) link_clk = ~link_clk;
    end
    task automatic step(input int n);
        repeat (n) @(posedge link_clk);
        #1;
    endtask
    task automatic open_frame();
        run = 1'b1;
        step(2);
        link_cs_n = 1'b0;
        for (int i = 0; i < 40 && link_rd_ready !== 1'b1; i++) step(1);
    endtask
    task automatic close_frame();
        for (int i = 0; i < 40 && link_wr_ready !== 1'b1; i++) step(1);
        link_cs_n = 1'b1;
        step(4);
        run = 1'b0;
    endtask
    task automatic rd_at(input logic [ADDR_W-1:0] a);
        {link_rd_addr, link_rd_start} = {a, 1'b1};
        step(1);
        {link_rd_addr, link_rd_start} = {~a, 1'b0};
    endtask
    task automatic rd_word(output logic [WORD_W-1:0] d);
        link_rd_next = 1'b1;
        step(1);
        link_rd_next = 1'b0;
        step(1);
        d = link_rdata;
    endtask
    // never aimed at the comparator snapshot, which would disturb conversion
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
        {link_wr_addr, link_wr_data, link_wr} = {a, d, 1'b1};
        for (int i = 0; i < 40 && link_wr_ready !== 1'b1; i++) step(1);
        step(1);
        {link_wr_addr, link_wr_data, link_wr} = {~a, ~d, 1'b0};
    endtask
endmodule
`default_nettype wire

/* File: tb_adc_result_and_delay_regs.sv */
// self-checking bench for the result and delay register block
`timescale 1ns/1ps
`default_nettype none
module tb_adc_result_and_delay_regs
    import adc_result_pkg::*;
;
    logic clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, mod_tick = 1'b0, tick_en = 1'b0;
    logic ready_link_enable = 1'b0, offset_correction_enable = 1'b0, gain_correction_enable = 1'b0;
    logic [1:0] result_width_select = WSEL_24, read_increment_select = INC_ALL;
    logic [WORD_W-1:0] comp_in = 32'h1e1e1e1e;
    logic [NUM_CH-1:0] conv_ready = 8'h00, chan_active = 8'hff, chan_restart, chan_start, rs;
    logic [NUM_CH-1:0][RES_W-1:0] conv_raw, conv_corr;
    logic ready_pin_n, link_clk, link_cs_n, link_rd_start, link_rd_next, link_rd_ready;
    logic link_wr, link_wr_ready;
    logic [ADDR_W-1:0] link_rd_addr, link_wr_addr;
    logic [WORD_W-1:0] link_rdata, link_wr_data, d;
    int num_errors = 0, compares = 0, cyc = 0, n_rdy = 0, tk = 0, d0 = 0, d2 = 0;
    logic [1:0] fmt_s [4] = '{WSEL_16, WSEL_24, WSEL_32_ZERO, WSEL_32_SIGN};
    logic [31:0] fmt_e [4] = '{32'h00009235, 32'h00923480, 32'h92348000, 32'hff923480};
    logic [1:0] inc_s [3] = '{INC_GROUP, INC_TYPE, INC_GROUP};
    logic [4:0] inc_a [3] = '{5'h01, 5'h07, 5'h05};
    int inc_b [3] = '{0, 0, 4};
    adc_result_and_delay_regs adc_result_and_delay_regs_i (.clk, .sys_rst, .ce, .mod_tick,
        .comp_in, .conv_ready, .conv_raw, .conv_corr, .chan_active, .chan_restart, .chan_start,
        .ready_pin_n, .ready_link_enable, .offset_correction_enable, .gain_correction_enable,
        .result_width_select, .read_increment_select, .link_clk, .link_cs_n, .link_rd_start,
        .link_rd_addr, .link_rd_next, .link_rd_ready, .link_rdata, .link_wr, .link_wr_addr,
        .link_wr_data, .link_wr_ready);
    host_link_model host (.link_clk, .link_cs_n, .link_rd_start, .link_rd_addr, .link_rd_next,
        .link_wr, .link_wr_addr, .link_wr_data, .link_rd_ready, .link_rdata, .link_wr_ready);
    always #2.5 clk = ~clk;
    // ticks are counted from the reference start, so a fixed offset cancels in the step
    always @(negedge clk) begin
        cyc <= cyc + 1;
        mod_tick <= tick_en && (cyc % 4 == 3);
        if (chan_start[0] === 1'b1) d0 = tk;
        if (chan_start[2] === 1'b1) d2 = tk;
        if (chan_start[1] === 1'b1) tk = 0;
        else if (mod_tick === 1'b1) tk = tk + 1;
        if (ready_pin_n === 1'b0) n_rdy = n_rdy + 1;
        if (chan_restart !== 8'h00) rs = chan_restart;
        if (cyc == 30000) begin
            num_errors = num_errors + 1;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (num_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares = compares + 1;
        if (g !== e) begin
            num_errors = num_errors + 1;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic conv(input logic [7:0] m);
        @(negedge clk);
        conv_ready = m;
        @(negedge clk);
        conv_ready = 8'h00;
    endtask
    task automatic rdf(input logic [4:0] a, input string nm, input logic [31:0] e);
        host.open_frame();
        host.rd_at(a);
        host.rd_word(d);
        chk(nm, e, d);
        host.close_frame();
    endtask
    task automatic wrf(input logic [4:0] a, input logic [31:0] v);
        rs = 8'h00;
        host.open_frame();
        host.wr(a, v);
        host.close_frame();
        repeat (40) @(negedge clk);
    endtask
    initial begin
        for (int i = 0; i < NUM_CH; i++) begin
            {conv_raw[i], conv_corr[i]} = {4'(i), 20'h12345, 4'(~i), 20'h0};
        end
        conv_raw[0] = 24'h923480;
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        host.close_frame();
        host.open_frame();
        host.rd_at(ADDR_RESULT_0);
        for (int i = 0; i < 12; i++) begin
            host.rd_word(d);
            chk("reset map", (i == 8) ? COMP_RST : 32'h0, d);
        end
        host.close_frame();
        @(negedge clk);
        {comp_in, tick_en} = {32'h8421c3a5, 1'b1};
        conv(8'h04);
        conv(8'hff);
        rdf(ADDR_COMP, "snapshot", 32'h8421c3a5);
        foreach (fmt_e[k]) begin
            @(negedge clk);
            {result_width_select, read_increment_select} = {fmt_s[k], INC_STATIC};
            host.open_frame();
            host.rd_at(ADDR_RESULT_0);
            repeat (2) begin
                host.rd_word(d);
                chk("format", fmt_e[k], d);
            end
            host.close_frame();
        end
        @(negedge clk);
        {result_width_select, read_increment_select} = {WSEL_24, INC_ALL};
        host.open_frame();
        host.rd_at(ADDR_RESULT_0);
        for (int i = 0; i < 8; i++) begin
            host.rd_word(d);
            chk("result", {8'h00, conv_raw[i]}, d);
        end
        host.close_frame();
        foreach (inc_s[k]) begin
            @(negedge clk);
            read_increment_select = inc_s[k];
            host.open_frame();
            host.rd_at(inc_a[k]);
            host.rd_word(d);
            host.rd_word(d);
            chk("address wrap", {8'h00, conv_raw[inc_b[k]]}, d);
            host.close_frame();
        end
        for (int k = 0; k < 3; k++) begin
            @(negedge clk);
            {offset_correction_enable, gain_correction_enable} = {k == 0, k == 1};
            conv(8'hff);
            rdf(5'h02, "correction", {8'h00, (k < 2) ? conv_corr[2] : conv_raw[2]});
        end
        host.open_frame();
        host.rd_at(5'h03);
        @(negedge clk);
        conv_raw[3] = 24'h0a0b0c;
        conv(8'h08);
        host.step(1);
        host.rd_word(d);
        chk("frozen word", 32'h00312345, d);
        host.close_frame();
        rdf(5'h03, "newest result", 32'h000a0b0c);
        @(negedge clk);
        {ready_link_enable, chan_active, conv_raw[0], n_rdy} = {1'b1, 8'h0f, 24'h055aa0, 32'h0};
        conv(8'h01);
        conv(8'h02);
        conv(8'h04);
        chk("early pulses", 32'h0, n_rdy);
        rdf(ADDR_RESULT_0, "held result", 32'h00923480);
        conv(8'h08);
        repeat (3) @(negedge clk);
        chk("linked pulses", 32'h1, n_rdy);
        rdf(ADDR_RESULT_0, "linked result", 32'h00055aa0);
        @(negedge clk);
        {ready_link_enable, chan_active} = {1'b0, 8'hff};
        wrf(ADDR_DLY_LO, 32'h00005003);
        chk("restart mask", 8'hff, rs);
        chk("delay step", 32'h2, d2 - d0);
        rdf(ADDR_DLY_LO, "lower delays", 32'h00005003);
        wrf(ADDR_DLY_HI, 32'hffabc123);
        chk("restart mask", 8'hff, rs);
        rdf(ADDR_DLY_HI, "upper delays", 32'h00abc123);
        wrf(5'h01, 32'h00ffffff);
        chk("result write restart", 8'h00, rs);
        rdf(5'h01, "result after write", 32'h00112345);
        end_of_test();
    end
endmodule
`default_nettype wire
